// >>> rtl/osc_trim_params.svh
// Offsets, reset values, the config write mask, the trim limit and timing figures for the
// oscillator trim, spread sweep and supply monitor block.
// Assumes the includer compiles it once; guard below.
`ifndef OSC_TRIM_PARAMS_SVH
`define OSC_TRIM_PARAMS_SVH

`define ADDR_W              16
`define OFS_REGULATOR_TRIM  16'ha000
`define OFS_OSC_COARSE_TRIM 16'ha001
`define OFS_OSC_FINE_TRIM   16'ha002
`define OFS_SUPPLY_MON_CFG  16'ha010
`define OFS_IRQ_STATUS      16'ha018
`define OFS_IRQ_MASK        16'ha019

`define RST_REGULATOR_TRIM  8'hff
`define RST_OSC_COARSE_TRIM 8'h02
`define RST_OSC_FINE_TRIM   8'h8e
`define RST_SUPPLY_MON_CFG  8'h80
`define RST_IRQ_MASK        2'h0

`define CFG_WR_MASK         8'hf8
`define TRIM_MAX            10'h0ff
`define FILTER_TIME_NS      30000
`define CLK_PERIOD_NS       40
`endif

// >>> rtl/osc_trim_pkg.sv
// Types for the oscillator trim and supply monitor block.
// Assumes the constants header is included by the design file.
package osc_trim_pkg;

	typedef enum logic [1:0] {
		dev_4,
		dev_8,
		dev_16,
		dev_32
	} amp_code_t;

	typedef struct packed {
		logic [3:0] spread_step_interval;
		amp_code_t  spread_amplitude_code;
		logic [1:0] coarse_range_sel;
	} coarse_ctl_t;

	typedef struct packed {
		logic lv_detect_on;
		logic lv_reset_on;
		logic lv_irq_on;
		logic lv_filter_on;
		logic reset_pin_filter_on;
		logic [1:0] unused;
		logic lv_irq_flag;
	} lv_config_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef struct packed {
		logic [7:0] main_regulator_trim;
		logic [1:0] coarse_range_sel;
		logic [7:0] effective_fine_trim;
	} analog_out_t;

endpackage

// >>> rtl/osc_trim_spread_and_supply_monitor.sv
// Register block for regulator trim, oscillator trims with spread sweep,
// and the supply low-voltage monitor with filters and interrupt.
// Assumes clk_sys is the fast internal oscillator and rst the system reset;
// the analog comparator and reset pin arrive synchronous to clk_sys.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "osc_trim_params.svh"

// Contract
// RL1: Regulator trim is 8 bits, driven straight to the analog trim input.
// RL2: Step interval zero disables spread; fine trim passes unchanged.
// RL3: Amplitude code selects deviation of 4, 8, 16 or 32 steps.
// RL4: With spread on, output is fine trim plus a swept offset.
// RL5: Offset updates every interval cycles; sweep lasts 4*interval*(2*dev+1). Code sweeps in 4*interval*dev cycles.
// RL6: Effective fine trim saturates at 0 and 255.
// RL7: Every reset returns oscillator trims to their defaults.
// RL8: Coarse range select in bits 1..0 picks one of four ranges.
// RL9: Software calibrates at range 01 by binary search of fine trim.
// RL10: Detect enable powers comparator; no event while it is clear.
// RL11: Reset enable lets a detection cause a system reset.
// RL12: Interrupt enable lets a detection raise the CPU interrupt.
// RL13: Detector filter rejects pulses shorter than about 30 us.
// RL14: Reset pin filter rejects glitches shorter than about 30 us.
// RL15: Detection sets a sticky flag; software clears it by writing one.
// RL16: Oscillator runs except in stop mode, gated glitch free.
// RL17: After reset the fast oscillator is the system clock source.
// RL18: Sweep is a triangle counter stepping once per interval.
module osc_trim_spread_and_supply_monitor
	import osc_trim_pkg::*;
#(
	parameter int FILTER_CYCLES = (`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire bus_req_t          bus_req,
	output      logic [7:0]        rdata,
	input  wire logic              supply_low_raw,
	input  wire logic              external_reset_pin_n,
	input  wire logic              stop_mode,
	output      analog_out_t       analog_out,
	output      logic              lv_detect_power,
	output      logic              osc_enable,
	output      logic              sys_clk_sel_fast,
	output      logic              reset_request,
	output      logic              irq
);

	localparam int FW = $clog2(FILTER_CYCLES + 1);
	localparam logic [FW-1:0] FILT_MAX = FW'(FILTER_CYCLES);

	typedef struct packed {
		logic [7:0]        main_regulator_trim;
		coarse_ctl_t       coarse;
		logic [7:0]        fine_trim_value;
		lv_config_t        cfg;
		logic [1:0]        irq_status;   // bit0 detection, bit1 pin reset
		logic [1:0]        irq_mask;
		logic [7:0]        rdata;
		logic [7:0]        eff_trim;
		logic signed [6:0] offset;
		logic              dir_down;
		logic [3:0]        step_cnt;
		logic [FW-1:0]     lv_cnt;
		logic              lv_level;
		logic [FW-1:0]     pin_cnt;
		logic              pin_level;
		logic              rst_req;
	} state_t;

	state_t s;
	state_t next_s;

	logic signed [6:0] dev;
	logic              det_event;
	logic              pin_event;
	logic signed [9:0] sum;
	logic [1:0]        clr_bits;

	// Next state: bus access, sweep, filters and event flags
	always_comb begin
		next_s = s;
		dev = 7'sd4 <<< s.coarse.spread_amplitude_code; // RL3
		clr_bits = 2'h0;
		det_event = 1'b0;
		pin_event = 1'b0;
		sum = 10'sd0;

		// Register writes
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				`OFS_REGULATOR_TRIM:  next_s.main_regulator_trim = bus_req.wdata; // RL1
				`OFS_OSC_COARSE_TRIM: next_s.coarse = coarse_ctl_t'(bus_req.wdata); // RL8
				`OFS_OSC_FINE_TRIM:   next_s.fine_trim_value = bus_req.wdata;
				`OFS_SUPPLY_MON_CFG: begin
					next_s.cfg = lv_config_t'((bus_req.wdata & `CFG_WR_MASK)
						| {7'h00, s.cfg.lv_irq_flag});
					clr_bits[0] = bus_req.wdata[0]; // RL15
				end
				`OFS_IRQ_STATUS:      clr_bits = bus_req.wdata[1:0];
				`OFS_IRQ_MASK:        next_s.irq_mask = bus_req.wdata[1:0];
				default: ;
			endcase
		end

		// Read data stands the cycle after the strobe only
		next_s.rdata = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`OFS_REGULATOR_TRIM:  next_s.rdata = s.main_regulator_trim;
				`OFS_OSC_COARSE_TRIM: next_s.rdata = s.coarse;
				`OFS_OSC_FINE_TRIM:   next_s.rdata = s.fine_trim_value;
				`OFS_SUPPLY_MON_CFG:  next_s.rdata = s.cfg;
				`OFS_IRQ_STATUS:      next_s.rdata = {6'h00, s.irq_status};
				`OFS_IRQ_MASK:        next_s.rdata = {6'h00, s.irq_mask};
				default:              next_s.rdata = 8'h00;
			endcase
		end

		// Triangle sweep; interval zero parks the offset at zero
		if (s.coarse.spread_step_interval == 4'h0) begin
			next_s.offset = 7'sd0; // RL2
			next_s.step_cnt = 4'h0;
			next_s.dir_down = 1'b0;
		end else if (s.step_cnt + 4'h1 >= s.coarse.spread_step_interval) begin
			next_s.step_cnt = 4'h0; // RL5
			// Amplitude change mid sweep pulls the offset back in range
			if (s.offset > dev) begin
				next_s.offset = dev;
				next_s.dir_down = 1'b1;
			end else if (s.offset < -dev) begin
				next_s.offset = -dev;
				next_s.dir_down = 1'b0;
			end else if (!s.dir_down) begin
				next_s.offset = s.offset + 7'sd1; // RL18
				if (s.offset + 7'sd1 >= dev) next_s.dir_down = 1'b1;
			end else begin
				next_s.offset = s.offset - 7'sd1; // RL18
				if (s.offset - 7'sd1 <= -dev) next_s.dir_down = 1'b0;
			end
		end else begin
			next_s.step_cnt = s.step_cnt + 4'h1;
		end

		// Offset applied with saturation instead of wrap
		// Interval zero ignores a stale offset so the fixed trim holds at once
		if (s.coarse.spread_step_interval == 4'h0) begin
			sum = $signed({2'b00, s.fine_trim_value}); // RL2
		end else begin
			sum = $signed({2'b00, s.fine_trim_value}) + 10'(s.offset); // RL4
		end
		if (sum < 10'sd0) next_s.eff_trim = 8'h00; // RL6
		else if (sum > $signed(`TRIM_MAX)) next_s.eff_trim = 8'hff; // RL6
		else next_s.eff_trim = sum[7:0];

		// Detector filter: level must hold the full window when enabled
		if (!s.cfg.lv_detect_on) begin
			next_s.lv_cnt = '0; // RL10
			next_s.lv_level = 1'b0;
		end else if (!supply_low_raw) begin
			next_s.lv_cnt = '0;
			next_s.lv_level = 1'b0;
		end else if (!s.cfg.lv_filter_on || s.lv_cnt >= FILT_MAX) begin
			next_s.lv_level = 1'b1; // RL13
		end else begin
			next_s.lv_cnt = s.lv_cnt + FW'(1);
		end
		det_event = next_s.lv_level && !s.lv_level;

		// Reset pin filter, same structure; active low pin
		if (external_reset_pin_n) begin
			next_s.pin_cnt = '0;
			next_s.pin_level = 1'b0;
		end else if (!s.cfg.reset_pin_filter_on || s.pin_cnt >= FILT_MAX) begin
			next_s.pin_level = 1'b1; // RL14
		end else begin
			next_s.pin_cnt = s.pin_cnt + FW'(1);
		end
		pin_event = next_s.pin_level && !s.pin_level;

		// Sticky flags: a new event wins over a same-cycle clear
		next_s.irq_status = (s.irq_status & ~clr_bits) | {pin_event, det_event};
		if (clr_bits[0]) next_s.cfg.lv_irq_flag = 1'b0;
		if (det_event) next_s.cfg.lv_irq_flag = 1'b1; // RL15

		next_s.rst_req = (s.cfg.lv_reset_on && s.lv_level) || s.pin_level; // RL11
	end

	// State register; every trim returns to its default on reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
			s.main_regulator_trim <= `RST_REGULATOR_TRIM; // RL7
			s.coarse <= coarse_ctl_t'(`RST_OSC_COARSE_TRIM); // RL7
			s.fine_trim_value <= `RST_OSC_FINE_TRIM; // RL7
			s.cfg <= lv_config_t'(`RST_SUPPLY_MON_CFG);
			s.eff_trim <= `RST_OSC_FINE_TRIM;
			s.irq_mask <= `RST_IRQ_MASK;
		end else begin
			s <= next_s;
		end
	end

	// Outputs
	assign rdata = s.rdata;
	assign analog_out.main_regulator_trim = s.main_regulator_trim; // RL1
	assign analog_out.coarse_range_sel = s.coarse.coarse_range_sel; // RL8
	assign analog_out.effective_fine_trim = s.eff_trim; // RL4
	assign lv_detect_power = s.cfg.lv_detect_on; // RL10
	// Analog oscillator gates itself cleanly; we only drive a level
	assign osc_enable = !stop_mode; // RL16
	assign sys_clk_sel_fast = 1'b1; // RL17
	assign reset_request = s.rst_req; // RL11
	// Legacy enable routes the flag; mask covers both status bits
	assign irq = (s.cfg.lv_irq_on && s.cfg.lv_irq_flag) // RL12
		|| |(s.irq_status & s.irq_mask);

endmodule

// >>> testbench/osc_trim_monitor.sv
// Checker for the trim, sweep and supply monitor block, bound to its top.
// Assumes every register write arrives through bus_req.
`timescale 1ns/1ps
module osc_trim_monitor
	import osc_trim_pkg::*;
#(
	parameter int FILTER_CYCLES = 750
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire bus_req_t    bus_req,
	input wire logic [7:0]  rdata,
	input wire logic        supply_low_raw,
	input wire logic        stop_mode,
	input wire analog_out_t analog_out,
	input wire logic        lv_detect_power,
	input wire logic        osc_enable,
	input wire logic        sys_clk_sel_fast,
	input wire logic        reset_request,
	input wire logic        irq
);
	logic [7:0] ctl, fine, cfg;
	// Register shadows; flag bit of cfg is not tracked
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctl <= 8'h02;
			fine <= 8'h8e;
			cfg <= 8'h80;
		end else if (bus_req.wr) begin
			if (bus_req.addr == 16'ha001) ctl <= bus_req.wdata;
			if (bus_req.addr == 16'ha002) fine <= bus_req.wdata;
			if (bus_req.addr == 16'ha010) cfg <= bus_req.wdata;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_osc_gate: assert property (osc_enable == !stop_mode)
		else $error("osc enable wrong");
	a_clk_source: assert property (sys_clk_sel_fast)
		else $error("fast clock not selected");
	a_reg_readback: assert property (bus_req.rd && bus_req.addr == 16'ha000
		|=> rdata == analog_out.main_regulator_trim) else $error("regulator trim mismatch");
	a_detect_power: assert property (cfg[7] [*3] |-> lv_detect_power)
		else $error("detector not powered");
	a_fixed_trim: assert property (ctl[7:4] == 4'h0
		|=> analog_out.effective_fine_trim == $past(fine)) else $error("fine trim not passed");
	a_step_one: assert property (ctl[7:4] != 4'h0 && $stable(ctl) && $stable(fine)
		|=> 8'(analog_out.effective_fine_trim - $past(analog_out.effective_fine_trim))
		inside {8'h00, 8'h01, 8'hff}) else $error("sweep step too large");
	a_range_out: assert property ($stable(ctl) |-> analog_out.coarse_range_sel == ctl[1:0])
		else $error("coarse range mismatch");
	a_reset_vals: assert property ($fell(rst) |-> analog_out.effective_fine_trim == 8'h8e
		&& analog_out.main_regulator_trim == 8'hff) else $error("trim not at default");
	a_lv_reset: assert property (cfg[7] && cfg[6] && !cfg[4] && supply_low_raw
		|-> ##[1:2] reset_request) else $error("no reset request");
	a_lv_irq: assert property (cfg[7] && cfg[5] && !cfg[4] && supply_low_raw
		|-> ##[1:2] irq) else $error("no interrupt");
	c_sat: cover property (ctl[7:4] != 4'h0 && analog_out.effective_fine_trim == 8'hff);
	c_rreq: cover property ($rose(reset_request));
	c_irq: cover property ($rose(irq));
endmodule
bind osc_trim_spread_and_supply_monitor osc_trim_monitor #(.FILTER_CYCLES(FILTER_CYCLES))
	osc_trim_monitor_inst (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rdata(rdata),
	.supply_low_raw(supply_low_raw), .stop_mode(stop_mode), .analog_out(analog_out),
	.lv_detect_power(lv_detect_power), .osc_enable(osc_enable),
	.sys_clk_sel_fast(sys_clk_sel_fast), .reset_request(reset_request), .irq(irq));

// >>> testbench/osc_trim_spread_and_supply_monitor_bench.sv
// Self-checking bench: register tasks, sweep sampling, detector and pin pulses.
// Assumes the filter shortened to 4 cycles so pulses stay short.
`timescale 1ns/1ps
module osc_trim_spread_and_supply_monitor_bench;
	import osc_trim_pkg::*;
	logic        clk_sys, rst, raw, pin_n, stop, pwr, osc_en, fast, rreq, irq, seen;
	bus_req_t    b;
	logic [7:0]  rdata, lo, hi;
	analog_out_t ao;
	int          err_count, comparisons, ch;
	osc_trim_spread_and_supply_monitor #(.FILTER_CYCLES(4)) osc_trim_spread_and_supply_monitor_inst (
		.clk_sys(clk_sys), .rst(rst), .bus_req(b), .rdata(rdata), .supply_low_raw(raw),
		.external_reset_pin_n(pin_n), .stop_mode(stop), .analog_out(ao), .lv_detect_power(pwr),
		.osc_enable(osc_en), .sys_clk_sel_fast(fast), .reset_request(rreq), .irq(irq));
	task tk(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		b <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		b <= '0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		b <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		b <= '0;
		#1;
		chk(rdata, e);
	endtask
	// Holds comparator high or pin low for n+1 edges, watching reset_request
	task pulse(input bit pin, input int n);
		seen = 0;
		@(posedge clk_sys);
		raw <= !pin;
		pin_n <= !pin;
		repeat (n + 3) begin
			tk(1);
			seen |= rreq;
			if (n-- == 0) begin
				raw <= 1'b0;
				pin_n <= 1'b1;
			end
		end
	endtask
	// Sweep extremes and number of output changes over n cycles
	task sw(input int n);
		logic [7:0] p;
		lo = 8'hff;
		hi = 8'h00;
		ch = 0;
		p = ao.effective_fine_trim;
		repeat (n) begin
			tk(1);
			lo = (ao.effective_fine_trim < lo) ? ao.effective_fine_trim : lo;
			hi = (ao.effective_fine_trim > hi) ? ao.effective_fine_trim : hi;
			ch += int'(ao.effective_fine_trim !== p);
			p = ao.effective_fine_trim;
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Bench runs near 2150 cycles; ten thousand means a hang
	initial begin
		#400000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		{rst, raw, pin_n, stop, b, err_count, comparisons} = {4'b1010, 26'h0, 64'h0};
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(16'ha010, 8'h80);
		for (int i = 0; i < 4; i++) begin
			wr(16'ha000, 8'(8'h55 * i));
			wr(16'ha001, 8'(i));
			tk(2);
			chk(ao.main_regulator_trim, 8'(8'h55 * i));
			chk({6'h0, ao.coarse_range_sel}, 8'(i));
		end
		wr(16'ha001, 8'h01);
		wr(16'ha002, 8'h00);
		tk(2);
		chk(ao.effective_fine_trim, 8'h00);
		chk({6'h0, ao.coarse_range_sel}, 8'h01);
		wr(16'ha002, 8'hff);
		tk(2);
		chk(ao.effective_fine_trim, 8'hff);
		wr(16'ha002, 8'h7f);
		tk(2);
		chk(ao.effective_fine_trim, 8'h7f);
		wr(16'ha003, 8'h5a);
		rd(16'ha003, 8'h00);
		wr(16'ha002, 8'h80);
		for (int i = 0; i < 4; i++) begin
			wr(16'ha001, {4'h1, 2'(i), 2'h0});
			sw(300);
			chk(hi, 8'(8'h80 + (8'h04 << i)));
			chk(lo, 8'(8'h80 - (8'h04 << i)));
		end
		wr(16'ha002, 8'hf0);
		sw(300);
		chk(hi, 8'hff);
		wr(16'ha002, 8'h10);
		sw(300);
		chk(lo, 8'h00);
		$display("test trims and sweep finished");
		wr(16'ha000, 8'h5a);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(16'ha000, 8'hff);
		rd(16'ha001, 8'h02);
		rd(16'ha002, 8'h8e);
		wr(16'ha001, 8'h40);
		tk(20);
		sw(144);
		chk(8'(ch), 8'h24);
		$display("test reset and sweep rate finished");
		wr(16'ha010, 8'ha0);
		pulse(0, 4);
		chk({7'h0, irq}, 8'h01);
		rd(16'ha010, 8'ha1);
		wr(16'ha010, 8'ha1);
		rd(16'ha010, 8'ha0);
		chk({7'h0, irq}, 8'h00);
		wr(16'ha010, 8'h20);
		pulse(0, 4);
		rd(16'ha010, 8'h20);
		wr(16'ha010, 8'hc0);
		pulse(0, 4);
		chk({7'h0, seen}, 8'h01);
		wr(16'ha010, 8'h80);
		pulse(0, 4);
		chk({7'h0, seen}, 8'h00);
		wr(16'ha010, 8'h91);
		pulse(0, 3);
		rd(16'ha010, 8'h90);
		pulse(0, 4);
		rd(16'ha010, 8'h91);
		$display("test detector finished");
		wr(16'ha010, 8'h08);
		wr(16'ha018, 8'h03);
		pulse(1, 3);
		rd(16'ha018, 8'h00);
		pulse(1, 4);
		rd(16'ha018, 8'h02);
		chk({7'h0, seen}, 8'h01);
		chk({7'h0, irq}, 8'h00);
		wr(16'ha019, 8'h02);
		tk(1);
		chk({7'h0, irq}, 8'h01);
		wr(16'ha018, 8'h02);
		tk(1);
		chk({7'h0, irq}, 8'h00);
		@(posedge clk_sys);
		stop <= 1'b1;
		tk(1);
		chk({7'h0, osc_en}, 8'h00);
		chk({7'h0, fast}, 8'h01);
		stop <= 1'b0;
		$display("test pin, interrupt and clock finished");
		tally_and_finish();
	end
endmodule
